/* File: shared/bridge_regs_defines.svh */
`ifndef BRIDGE_REGS_DEFINES_SVH
`define BRIDGE_REGS_DEFINES_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define ADDR_LATENCY_LAYOUT   12'h00C
`define ADDR_BUS_NUMBERS      12'h018
`define ADDR_IO_STATUS        12'h01C
`define ADDR_IO_UPPER         12'h030
`define ADDR_CONTROL          12'h03C

// ---------------------------------------------------------------
// constant fields
// ---------------------------------------------------------------
`define LAYOUT_TYPE_VALUE     8'h01
`define IO_ADDR32_CODE        4'h1
`define CLAIM_TIMING_MEDIUM   2'h1
`define IO_LOW_ZERO           12'h000
`define IO_LOW_ONES           12'hFFF

// ---------------------------------------------------------------
// status and control bit positions
// ---------------------------------------------------------------
`define ST_FAST66             21
`define ST_FBB                23
`define ST_PARITY_RPT         24
`define ST_SIG_TABORT         27
`define ST_RCV_TABORT         28
`define ST_RCV_MABORT         29
`define ST_SYS_ERR            30
`define ST_PARITY_DET         31
`define CMD_PARITY_RESP_BIT   6

`endif

/* File: shared/bridge_regs_pkg.sv */
package bridge_regs_pkg;
	// sticky flags in status order: bit 24,27,28,29,30,31
	typedef struct packed {
		logic parity_det;
		logic sys_err;
		logic rcv_mabort;
		logic rcv_tabort;
		logic sig_tabort;
		logic parity_rpt;
	} sticky_t;

	typedef enum logic [1:0] {
		LT_IDLE    = 2'b00,
		LT_RUNNING = 2'b01,
		LT_EXPIRED = 2'b10
	} lat_state_t;
endpackage : bridge_regs_pkg

/* File: shared/latency_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface latency_if;
	logic       frame_start;
	logic       active;
	logic [7:0] load_value;
	logic       expired;
	modport ctrl (output frame_start, output active, output load_value, input expired);
	modport timer (input frame_start, input active, input load_value, output expired);
endinterface : latency_if
`default_nettype wire

/* File: tb/bridge_bus_window_status_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bridge_regs_defines.svh"
module bridge_bus_window_status_regs_bench;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e, go_i;
	logic        ds_frame_start_i, ds_master_active_i, ds_grant_i, ds_data_done_i, ds_mwi_i;
	logic        us_frame_start_i, us_master_active_i, io_hit_o, us_latency_expired_o, ds_stop_o;
	logic        perr_n, serr_n;
	logic [2:0]  kind_i;
	logic [3:0]  pstrb_i, ev;
	logic [7:0]  sexp;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, io_addr_i, q;
	logic [7:0]  flag [6] = '{8'h08, 8'h10, 8'h20, 8'h80, 8'h01, 8'h40};
	logic [31:0] atab [5] = '{32'h12342000, 32'h12341FFF, 32'h12345FFF, 32'h12346000, 32'h12353000};
	logic [4:0]  htab = 5'b00101;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	bridge_bus_window_status_regs DUT (.clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
		.downstream_parity_err_n_i(perr_n), .downstream_system_err_n_i(serr_n),
		.ds_frame_start_i, .ds_master_active_i, .ds_grant_i, .ds_data_done_i, .ds_mwi_i,
		.ds_sig_tabort_i(ev[0]), .ds_rcv_tabort_i(ev[1]), .ds_rcv_mabort_i(ev[2]),
		.ds_parity_det_i(ev[3]), .us_frame_start_i, .us_master_active_i, .io_addr_i, .io_hit_o,
		.us_latency_expired_o, .ds_stop_o);
	ds_bus_agent agent (.clk_sys_i, .rstn_i, .go_i, .kind_i, .pulse_o(ev),
		.parity_err_n_o(perr_n), .system_err_n_o(serr_n));
	always #20 clk_sys_i = ~clk_sys_i;
	// a hang is cut short well past the few hundred cycles needed
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic fire(input logic [2:0] k);
		@(posedge clk_sys_i);
		go_i <= 1'b1;
		kind_i <= k;
		tick(1);
		go_i <= 1'b0;
		tick(6);
	endtask : fire
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i, go_i, kind_i, io_addr_i} = '0;
		{ds_frame_start_i, ds_master_active_i, ds_grant_i, ds_data_done_i, ds_mwi_i} = '0;
		{us_frame_start_i, us_master_active_i, rstn_i} = '0;
		tick(4);
		rstn_i <= 1'b1;
		apb(0, `ADDR_LATENCY_LAYOUT, 32'h0, 4'h0);
		chk("lat_layout", q[23:8], 32'h00000100);
		apb(0, `ADDR_BUS_NUMBERS, 32'h0, 4'h0);
		chk("bus_numbers", q, 32'h00000000);
		apb(0, `ADDR_IO_STATUS, 32'h0, 4'h0);
		chk("io_status", q, 32'h02A00101);
		apb(1, `ADDR_BUS_NUMBERS, 32'hA5C35A3C, 4'hF);
		apb(1, `ADDR_BUS_NUMBERS, 32'h00000000, 4'h1);
		apb(0, `ADDR_BUS_NUMBERS, 32'h0, 4'h0);
		chk("bus_numbers", q, 32'hA5C35A00);
		apb(1, `ADDR_LATENCY_LAYOUT, 32'hFFFFFFFF, 4'hF);
		apb(0, `ADDR_LATENCY_LAYOUT, 32'h0, 4'h0);
		chk("lat_layout", q[23:8], 32'h000001FF);
		apb(1, `ADDR_IO_STATUS, 32'hFFFFFFFF, 4'hF);
		apb(0, `ADDR_IO_STATUS, 32'h0, 4'h0);
		chk("io_status", q, 32'h02A0F1F1);
		apb(0, 12'h010, 32'h0, 4'h0);
		chk("unmapped_err", e, 32'h1);
		chk("unmapped_data", q, 32'h0);
		$display("test registers done");
		apb(1, `ADDR_IO_UPPER, 32'h00001234, 4'h3);
		apb(1, `ADDR_IO_STATUS, 32'h00005020, 4'h3);
		for (int i = 0; i < 5; i++) begin
			io_addr_i <= atab[i];
			tick(2);
			chk("io_hit", io_hit_o, htab[i]);
		end
		$display("test io_window done");
		sexp = 8'h02;
		fire(3'd4);
		apb(0, `ADDR_IO_STATUS, 32'h0, 4'h0);
		chk("status_hi", q[31:24], sexp);
		apb(1, `ADDR_CONTROL, 32'h00000040, 4'h1);
		for (int k = 0; k < 6; k++) begin
			fire(3'(k));
			sexp = sexp | flag[k];
			apb(0, `ADDR_IO_STATUS, 32'h0, 4'h0);
			chk("status_set", q[31:24], sexp);
		end
		for (int k = 0; k < 6; k++) begin
			apb(1, `ADDR_IO_STATUS, {flag[k], 24'h0}, 4'h8);
			sexp = sexp & ~flag[k];
			apb(0, `ADDR_IO_STATUS, 32'h0, 4'h0);
			chk("status_clr", q[31:24], sexp);
		end
		$display("test sticky done");
		apb(1, `ADDR_LATENCY_LAYOUT, 32'h00000400, 4'h2);
		apb(1, `ADDR_BUS_NUMBERS, 32'h04000000, 4'h8);
		{us_master_active_i, us_frame_start_i, ds_master_active_i, ds_frame_start_i} <= 4'hF;
		tick(1);
		{us_frame_start_i, ds_frame_start_i} <= 2'h0;
		tick(1);
		chk("us_exp_early", us_latency_expired_o, 32'h0);
		chk("ds_stop_early", ds_stop_o, 32'h0);
		tick(5);
		chk("us_exp", us_latency_expired_o, 32'h1);
		chk("ds_stop", ds_stop_o, 32'h1);
		{us_master_active_i, ds_master_active_i} <= 2'h0;
		tick(3);
		chk("us_exp_idle", us_latency_expired_o, 32'h0);
		apb(1, `ADDR_BUS_NUMBERS, 32'h00000000, 4'h8);
		{ds_master_active_i, ds_frame_start_i, ds_grant_i} <= 3'h7;
		tick(1);
		{ds_frame_start_i, ds_grant_i, ds_data_done_i} <= 3'h1;
		tick(1);
		ds_data_done_i <= 1'b0;
		e = 1'b0;
		repeat (3) begin
			tick(1);
			e = e | (ds_stop_o === 1'b1);
		end
		chk("zero_stop", e, 32'h1);
		ds_master_active_i <= 1'b0;
		$display("test timers done");
		report_and_stop();
	end
endmodule : bridge_bus_window_status_regs_bench
`default_nettype wire

/* File: tb/bridge_regs_checker_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bridge_regs_defines.svh"
module bridge_regs_checker (
	// clock, reset, apb
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	input  wire logic [31:0] prdata_o,
	input  wire logic        pready_o,
	input  wire logic        pslverr_o,
	// bus events and results
	input  wire logic        us_frame_start_i,
	input  wire logic        us_master_active_i,
	input  wire logic        ds_frame_start_i,
	input  wire logic        ds_master_active_i,
	input  wire logic        ds_grant_i,
	input  wire logic        ds_data_done_i,
	input  wire logic        ds_mwi_i,
	input  wire logic        us_latency_expired_o,
	input  wire logic        ds_stop_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	logic [7:0] us_lat;
	logic [7:0] ds_lat;
	logic       done;
	logic       rd;
	logic       mapped;
	assign done = psel_i && penable_i && pready_o;
	assign rd = done && !pwrite_i;
	assign mapped = paddr_i inside {`ADDR_LATENCY_LAYOUT, `ADDR_BUS_NUMBERS, `ADDR_IO_STATUS,
		`ADDR_IO_UPPER, `ADDR_CONTROL};
	// ------------------------------------------------------------
	// shadow of the latency bytes: writes land only on the ready edge
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			us_lat <= 8'h00;
			ds_lat <= 8'h00;
		end else if (done && pwrite_i && mapped) begin
			if (paddr_i == `ADDR_LATENCY_LAYOUT && pstrb_i[1])
				us_lat <= pwdata_i[15:8];
			if (paddr_i == `ADDR_BUS_NUMBERS && pstrb_i[3])
				ds_lat <= pwdata_i[31:24];
		end
	end
	sequence s_access; psel_i && penable_i && !pready_o; endsequence
	sequence s_rd_io; rd && paddr_i == `ADDR_IO_STATUS; endsequence
	property p_answer; s_access |=> pready_o; endproperty
	property p_refuse; done |-> pslverr_o == !mapped; endproperty
	property p_layout; rd && paddr_i == `ADDR_LATENCY_LAYOUT |-> prdata_o[23:16] == 8'h01; endproperty
	property p_io_code; s_rd_io |-> prdata_o[3:0] == 4'h1 && prdata_o[11:8] == 4'h1; endproperty
	property p_fast66; s_rd_io |-> prdata_o[22:16] == 7'h20; endproperty
	property p_fbb; s_rd_io |-> prdata_o[23]; endproperty
	property p_claim; s_rd_io |-> prdata_o[26:25] == 2'h1; endproperty
	property p_us_timer;
		us_frame_start_i && us_master_active_i && us_lat == 8'h04
			|=> !us_latency_expired_o [*2] ##[1:4] us_latency_expired_o;
	endproperty
	property p_ds_timer;
		ds_frame_start_i && ds_master_active_i && ds_lat == 8'h04
			|=> !ds_stop_o [*2] ##[1:4] ds_stop_o;
	endproperty
	property p_zero_stop;
		ds_lat == 8'h00 && ds_master_active_i && ds_data_done_i && !ds_grant_i && !ds_mwi_i
			|-> ##[1:2] ds_stop_o;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after one wait state");
	a_refuse: assert property (p_refuse) else $error("error response wrong for address");
	a_layout: assert property (p_layout) else $error("layout type wrong");
	a_io_code: assert property (p_io_code) else $error("io width code wrong");
	a_fast66: assert property (p_fast66) else $error("status bits 22:16 wrong");
	a_fbb: assert property (p_fbb) else $error("status bit 23 not set");
	a_claim: assert property (p_claim) else $error("claim timing wrong");
	a_us_timer: assert property (p_us_timer) else $error("upstream timer wrong");
	a_ds_timer: assert property (p_ds_timer) else $error("downstream timer wrong");
	a_zero_stop: assert property (p_zero_stop) else $error("no zero latency stop");
endmodule : bridge_regs_checker
bind bridge_bus_window_status_regs bridge_regs_checker chk_i (.clk_sys_i, .rstn_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
	.us_frame_start_i, .us_master_active_i, .ds_frame_start_i, .ds_master_active_i, .ds_grant_i,
	.ds_data_done_i, .ds_mwi_i, .us_latency_expired_o, .ds_stop_o);
`default_nettype wire

/* File: tb/ds_bus_agent.sv */
`timescale 1ns/10ps
`default_nettype none
module ds_bus_agent (
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	input  wire logic       go_i,
	input  wire logic [2:0] kind_i,
	output logic [3:0]      pulse_o,
	output logic            parity_err_n_o,
	output logic            system_err_n_o
);
	logic [1:0] hold;
	logic       pin_sel;
	// pins low two cycles so the far side synchroniser cannot miss them
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pulse_o <= 4'h0;
			hold <= 2'h0;
			pin_sel <= 1'b0;
		end else begin
			pulse_o <= (go_i && !kind_i[2]) ? 4'h1 << kind_i[1:0] : 4'h0;
			hold <= (go_i && kind_i[2]) ? 2'h2 : hold - {1'b0, hold != 2'h0};
			if (go_i)
				pin_sel <= kind_i[0];
		end
	end
	// pulled-up lines idle high
	assign parity_err_n_o = !(hold != 2'h0 && !pin_sel);
	assign system_err_n_o = !(hold != 2'h0 && pin_sel);
endmodule : ds_bus_agent
`default_nettype wire

/* File: verilog/bridge_bus_window_status_regs.sv */
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "bridge_regs_defines.svh"

module bridge_bus_window_status_regs (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// downstream bus pins, active low
	input  wire logic        downstream_parity_err_n_i,
	input  wire logic        downstream_system_err_n_i,
	// downstream bus events from the bridge engine
	input  wire logic        ds_frame_start_i,
	input  wire logic        ds_master_active_i,
	input  wire logic        ds_grant_i,
	input  wire logic        ds_data_done_i,
	input  wire logic        ds_mwi_i,
	input  wire logic        ds_sig_tabort_i,
	input  wire logic        ds_rcv_tabort_i,
	input  wire logic        ds_rcv_mabort_i,
	input  wire logic        ds_parity_det_i,
	// upstream bus events
	input  wire logic        us_frame_start_i,
	input  wire logic        us_master_active_i,
	// io address compare
	input  wire logic [31:0] io_addr_i,
	// results
	output logic             io_hit_o,
	output logic             us_latency_expired_o,
	output logic             ds_stop_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
		logic [7:0]              us_lat;
		logic [7:0]              us_bus;
		logic [7:0]              ds_bus;
		logic [7:0]              hi_bus;
		logic [7:0]              ds_lat;
		logic [3:0]              io_bot;
		logic [3:0]              io_top;
		logic [15:0]             io_upper;
		logic                    parity_resp;
		bridge_regs_pkg::sticky_t st;
		logic [1:0]              perr_sync;
		logic [1:0]              serr_sync;
		logic                    io_hit;
		logic                    us_exp;
		logic                    ds_stop;
	} state_t;

	state_t q;
	state_t next_q;

	latency_if us_lt ();
	latency_if ds_lt ();

	logic        win_hit;
	logic [31:0] rd_word;
	logic        mapped;
	logic        wr_acc;
	logic        ds_zero_stop;

	// ------------------------------------------------------------
	// latency timers
	// ------------------------------------------------------------
	assign us_lt.frame_start = us_frame_start_i;
	assign us_lt.active      = us_master_active_i;
	assign us_lt.load_value  = q.us_lat;
	assign ds_lt.frame_start = ds_frame_start_i;
	assign ds_lt.active      = ds_master_active_i;
	assign ds_lt.load_value  = q.ds_lat;

	latency_timer u_us_timer (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.lt        (us_lt.timer)
	);

	latency_timer u_ds_timer (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.lt        (ds_lt.timer)
	);

	io_window_match u_io_window (
		.upper_i  (q.io_upper),
		.bottom_i (q.io_bot),
		.top_i    (q.io_top),
		.addr_i   (io_addr_i),
		.hit_o    (win_hit)
	);

	// zero latency: release after first data when grant gone, mwi keeps going
	assign ds_zero_stop = (q.ds_lat == 8'h00) && ds_master_active_i && ds_data_done_i
		&& !ds_grant_i && !ds_mwi_i;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		mapped  = 1'b1;
		unique case (paddr_i)
			`ADDR_LATENCY_LAYOUT: begin
				rd_word = {8'h00, `LAYOUT_TYPE_VALUE, q.us_lat, 8'h00};
			end
			`ADDR_BUS_NUMBERS: begin
				rd_word = {q.ds_lat, q.hi_bus, q.ds_bus, q.us_bus};
			end
			`ADDR_IO_STATUS: begin
				rd_word[7:0]   = {q.io_bot, `IO_ADDR32_CODE};
				rd_word[15:8]  = {q.io_top, `IO_ADDR32_CODE};
				rd_word[`ST_FAST66] = 1'b1;
				rd_word[`ST_FBB]    = 1'b1;
				rd_word[26:25] = `CLAIM_TIMING_MEDIUM;
				rd_word[`ST_PARITY_RPT] = q.st.parity_rpt;
				rd_word[`ST_SIG_TABORT] = q.st.sig_tabort;
				rd_word[`ST_RCV_TABORT] = q.st.rcv_tabort;
				rd_word[`ST_RCV_MABORT] = q.st.rcv_mabort;
				rd_word[`ST_SYS_ERR]    = q.st.sys_err;
				rd_word[`ST_PARITY_DET] = q.st.parity_det;
			end
			`ADDR_IO_UPPER: begin
				rd_word = {16'h0000, q.io_upper};
			end
			`ADDR_CONTROL: begin
				rd_word[`CMD_PARITY_RESP_BIT] = q.parity_resp;
			end
			default: mapped = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// write lands on the edge at which the master samples pready high
	assign wr_acc = psel_i && penable_i && pwrite_i && q.pready && mapped;

	always_comb begin
		next_q = q;
		next_q.pready  = psel_i && penable_i && !q.pready;
		next_q.pslverr = psel_i && penable_i && !q.pready && !mapped;
		if (psel_i && penable_i && !q.pready && !pwrite_i) begin
			next_q.prdata = rd_word;
		end
		// pins cross in via two flops before any use
		next_q.perr_sync = {q.perr_sync[0], ~downstream_parity_err_n_i};
		next_q.serr_sync = {q.serr_sync[0], ~downstream_system_err_n_i};

		if (wr_acc) begin
			unique case (paddr_i)
				`ADDR_LATENCY_LAYOUT: begin
					if (pstrb_i[1]) next_q.us_lat = pwdata_i[15:8];
				end
				`ADDR_BUS_NUMBERS: begin
					if (pstrb_i[0]) next_q.us_bus = pwdata_i[7:0];
					if (pstrb_i[1]) next_q.ds_bus = pwdata_i[15:8];
					if (pstrb_i[2]) next_q.hi_bus = pwdata_i[23:16];
					if (pstrb_i[3]) next_q.ds_lat = pwdata_i[31:24];
				end
				`ADDR_IO_STATUS: begin
					if (pstrb_i[0]) next_q.io_bot = pwdata_i[7:4];
					if (pstrb_i[1]) next_q.io_top = pwdata_i[15:12];
					if (pstrb_i[3]) begin
						// write one clears; a same-cycle event re-sets below
						if (pwdata_i[`ST_PARITY_RPT]) next_q.st.parity_rpt = 1'b0;
						if (pwdata_i[`ST_SIG_TABORT]) next_q.st.sig_tabort = 1'b0;
						if (pwdata_i[`ST_RCV_TABORT]) next_q.st.rcv_tabort = 1'b0;
						if (pwdata_i[`ST_RCV_MABORT]) next_q.st.rcv_mabort = 1'b0;
						if (pwdata_i[`ST_SYS_ERR])    next_q.st.sys_err    = 1'b0;
						if (pwdata_i[`ST_PARITY_DET]) next_q.st.parity_det = 1'b0;
					end
				end
				`ADDR_IO_UPPER: begin
					if (pstrb_i[0]) next_q.io_upper[7:0]  = pwdata_i[7:0];
					if (pstrb_i[1]) next_q.io_upper[15:8] = pwdata_i[15:8];
				end
				`ADDR_CONTROL: begin
					if (pstrb_i[0]) next_q.parity_resp = pwdata_i[`CMD_PARITY_RESP_BIT];
				end
				default: ;
			endcase
		end

		// events win over a clear in the same cycle
		if (q.perr_sync[1] && q.parity_resp) next_q.st.parity_rpt = 1'b1;
		if (ds_sig_tabort_i) next_q.st.sig_tabort = 1'b1;
		if (ds_rcv_tabort_i) next_q.st.rcv_tabort = 1'b1;
		if (ds_rcv_mabort_i) next_q.st.rcv_mabort = 1'b1;
		if (q.serr_sync[1])  next_q.st.sys_err    = 1'b1;
		if (ds_parity_det_i) next_q.st.parity_det = 1'b1;

		next_q.io_hit  = win_hit;
		next_q.us_exp  = us_lt.expired;
		next_q.ds_stop = ds_lt.expired || ds_zero_stop;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata_o             = q.prdata;
	assign pready_o             = q.pready;
	assign pslverr_o            = q.pslverr;
	assign io_hit_o             = q.io_hit;
	assign us_latency_expired_o = q.us_exp;
	assign ds_stop_o            = q.ds_stop;
endmodule : bridge_bus_window_status_regs
`default_nettype wire

/* File: verilog/io_window_match.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bridge_regs_defines.svh"
module io_window_match (
	// window
	input  wire logic [15:0] upper_i,
	input  wire logic [3:0]  bottom_i,
	input  wire logic [3:0]  top_i,
	// address
	input  wire logic [31:0] addr_i,
	output logic             hit_o
);
	logic [31:0] lo;
	logic [31:0] hi;

	// ------------------------------------------------------------
	// window bounds
	// ------------------------------------------------------------
	assign lo    = {upper_i, bottom_i, `IO_LOW_ZERO};
	assign hi    = {upper_i, top_i, `IO_LOW_ONES};
	assign hit_o = (addr_i >= lo) && (addr_i <= hi);
endmodule : io_window_match
`default_nettype wire

/* File: verilog/latency_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module latency_timer (
	// clock and reset
	input  wire logic  clk_sys_i,
	input  wire logic  rstn_i,
	// control
	latency_if.timer   lt
);
	typedef struct packed {
		bridge_regs_pkg::lat_state_t st;
		logic [7:0]                  cnt;
	} state_t;

	state_t q;
	state_t next_q;

	always_comb begin
		next_q = q;
		unique case (q.st)
			bridge_regs_pkg::LT_IDLE: begin
				if (lt.frame_start) begin
					next_q.cnt = lt.load_value;
					next_q.st  = (lt.load_value == 8'h00) ? bridge_regs_pkg::LT_EXPIRED
						: bridge_regs_pkg::LT_RUNNING;
				end
			end
			bridge_regs_pkg::LT_RUNNING: begin
				if (!lt.active) begin
					next_q.st = bridge_regs_pkg::LT_IDLE;
				end else if (q.cnt <= 8'h01) begin
					next_q.cnt = 8'h00;
					next_q.st  = bridge_regs_pkg::LT_EXPIRED;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
			bridge_regs_pkg::LT_EXPIRED: begin
				if (!lt.active) begin
					next_q.st = bridge_regs_pkg::LT_IDLE;
				end
			end
			default: next_q.st = bridge_regs_pkg::LT_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '{st: bridge_regs_pkg::LT_IDLE, cnt: 8'h00};
		end else begin
			q <= next_q;
		end
	end

	assign lt.expired = (q.st == bridge_regs_pkg::LT_EXPIRED);
endmodule : latency_timer
`default_nettype wire
